// >>> src/cmit_regs.vh
// register offsets, fields, reset values and timing counts of the interval timer
`ifndef CMIT_REGS_VH
`define CMIT_REGS_VH
// register offsets (byte addresses, one word each)
`define CMIT_OFF_START 8'h00
`define CMIT_OFF_CSR 8'h04
`define CMIT_OFF_CNT 8'h08
`define CMIT_OFF_CONST 8'h0C
`define CMIT_OFF_WDCNT 8'h10
`define CMIT_OFF_IRQ_STAT 8'h14
`define CMIT_OFF_IRQ_EN 8'h18
`define CMIT_OFF_IRQ_CLR 8'h1C
`define CMIT_OFF_WDCTL 8'h20
// control/status fields
`define CMIT_CSR_CKS_LO 0
`define CMIT_CSR_CKS_HI 1
`define CMIT_CSR_IE 6
`define CMIT_CSR_FLAG 7
// start register field
`define CMIT_START_BIT 0
// watchdog control fields
`define CMIT_WD_EN 0
`define CMIT_WD_OVF 1
// interrupt status bits
`define CMIT_IRQ_MATCH 0
`define CMIT_IRQ_WDOVF 1
// clock select codes
`define CMIT_CKS_DIV4 2'h1
// divider ratios per select code
`define CMIT_DIV_SEL0 8'h08
`define CMIT_DIV_SEL1 8'h04
`define CMIT_DIV_SEL2 8'h20
`define CMIT_DIV_SEL3 8'h80
// reset values
`define CMIT_RST_CNT 16'h0000
`define CMIT_RST_CONST 16'hFFFF
`define CMIT_RST_WDCNT 8'h00
`define CMIT_RST_CKS 2'h0
`endif

// >>> src/cmit_prescaler.v
// prescaler producing one-cycle count enables from the system clock
`timescale 1ns/1ns
`default_nettype none
`include "cmit_regs.vh"
module cmit_prescaler (
    // clock and reset
    input wire CLK_IN,
    input wire RSTN_IN,
    // control
    input wire run_in,
    input wire [1:0] sel_in,
    // enable pulse
    output reg tick_out
);
    // free divider counter, cleared while stopped so first tick is a full period
    reg [7:0] div_r;
    // selected terminal count
    reg [7:0] ratio;

    // ratio lookup
    always @* begin
        case (sel_in)
            2'h0: ratio = `CMIT_DIV_SEL0;
            `CMIT_CKS_DIV4: ratio = `CMIT_DIV_SEL1;
            2'h2: ratio = `CMIT_DIV_SEL2;
            default: ratio = `CMIT_DIV_SEL3;
        endcase
    end

    // divider and tick
    always @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            div_r <= 8'h00;
            tick_out <= 1'b0;
        end else if (!run_in) begin
            div_r <= 8'h00;
            tick_out <= 1'b0;
        end else if (div_r >= ratio - 8'h01) begin
            // terminal count reached
            div_r <= 8'h00;
            tick_out <= 1'b1;
        end else begin
            div_r <= div_r + 8'h01;
            tick_out <= 1'b0;
        end
    end
endmodule // cmit_prescaler
`default_nettype wire

// >>> src/cmit_timer.v
// compare match interval timer with register port and interrupt
//
// Operation
// - status register: flag, irq enable, clock select
// - started counter increments on selected clock
// - match clears counter to zero
// - match sets the match flag
// - select 01 counts at clock over four
// - overflow or interrupt zeroes watchdog count
//
// Notes
// - the counter runs only on the internal prescaled tick
// - read data stand one cycle after the strobe, else zero
// - a match in the same cycle as a flag clear keeps the flag
// - a pending combined interrupt holds the watchdog count at zero
// - the first tick after a start comes one ratio plus one cycle late,
//   because the start bit itself is registered before the prescaler
// - the match request is an early copy of flag and enable, so the
//   outputs move in the same cycle as the register image
`timescale 1ns/1ns
`default_nettype none
`include "cmit_regs.vh"
module cmit_timer (
    // clock and reset
    input wire CLK_IN,
    input wire RSTN_IN,
    // register port
    input wire [7:0] ADDR_IN,
    input wire [31:0] WDATA_IN,
    input wire WR_IN,
    input wire RD_IN,
    output reg [31:0] RDATA_OUT,
    // watchdog overflow pin and interrupts
    // every output below comes straight from a flop
    output reg OVF_OUT,
    output reg MATCH_IRQ_OUT,
    output reg IRQ_OUT
);
    // count start bit
    reg count_start_bit_r;
    // clock select pair
    reg [1:0] clock_select_r;
    // match interrupt enable in control/status
    reg match_ie_r;
    // match flag, set by hardware, cleared by writing 0
    reg match_flag_r;
    // interval counter and constant
    reg [15:0] interval_counter_r;
    // constant resets to all ones, the longest interval
    reg [15:0] compare_constant_r;
    // watchdog count and its enable
    reg [7:0] watchdog_count_r;
    reg wd_en_r;
    // sticky event status and enable
    reg [1:0] irq_stat_r;
    reg [1:0] irq_en_r;
    // count tick, one cycle wide, from the prescaler
    wire tick;
    // decoded writes, exact address match only
    // start register
    wire wr_start = WR_IN && (ADDR_IN == `CMIT_OFF_START);
    // control/status and counter
    wire wr_csr = WR_IN && (ADDR_IN == `CMIT_OFF_CSR);
    wire wr_cnt = WR_IN && (ADDR_IN == `CMIT_OFF_CNT);
    // compare constant and watchdog count
    wire wr_const = WR_IN && (ADDR_IN == `CMIT_OFF_CONST);
    wire wr_wdcnt = WR_IN && (ADDR_IN == `CMIT_OFF_WDCNT);
    // interrupt enable and write-one clear
    wire wr_ien = WR_IN && (ADDR_IN == `CMIT_OFF_IRQ_EN);
    wire wr_iclr = WR_IN && (ADDR_IN == `CMIT_OFF_IRQ_CLR);
    // watchdog control
    wire wr_wdctl = WR_IN && (ADDR_IN == `CMIT_OFF_WDCTL);
    // match event: counter equals constant on a tick
    // compared only on a tick, so a stopped counter never matches
    wire match_ev = tick && (interval_counter_r == compare_constant_r);
    // watchdog overflow event
    // terminal count while enabled; the count then restarts at zero
    wire wd_ovf_ev = wd_en_r && (watchdog_count_r == 8'hFF);
    // events and level of the combined interrupt
    wire [1:0] events = {wd_ovf_ev, match_ev};
    // next status: clear first, a same-cycle event wins
    wire [1:0] stat_nxt = (irq_stat_r & ~({2{wr_iclr}} & WDATA_IN[1:0])) | events;
    // next enable, so a masking write drops the request at once
    wire [1:0] en_nxt = wr_ien ? WDATA_IN[1:0] : irq_en_r;
    // combined level of the next cycle
    wire irq_nxt = |(stat_nxt & en_nxt);
    // control/status read image: flag, enable, four zero bits, select
    wire [7:0] csr_val = {match_flag_r, match_ie_r, 4'h0, clock_select_r};

    // prescaled count enable
    // stopping clears the divider, so each start begins a full period
    cmit_prescaler u_pre (
        .CLK_IN(CLK_IN),
        .RSTN_IN(RSTN_IN),
        .run_in(count_start_bit_r),
        .sel_in(clock_select_r),
        .tick_out(tick)
    );

    // control, flag and counter registers
    // software writes land at the strobe edge; hardware events
    // are merged here so each register has one process
    always @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            // stopped, select zero, constant at all ones
            count_start_bit_r <= 1'b0;
            clock_select_r <= `CMIT_RST_CKS;
            match_ie_r <= 1'b0;
            match_flag_r <= 1'b0;
            interval_counter_r <= `CMIT_RST_CNT;
            compare_constant_r <= `CMIT_RST_CONST;
        end else begin
            // start bit: stopping also resets the prescaler phase
            if (wr_start) begin
                count_start_bit_r <= WDATA_IN[`CMIT_START_BIT];
            end
            if (wr_csr) begin
                clock_select_r <= WDATA_IN[`CMIT_CSR_CKS_HI:`CMIT_CSR_CKS_LO];
                match_ie_r <= WDATA_IN[`CMIT_CSR_IE];
            end
            // set wins over clear
            // a match is never lost to a racing software clear
            if (match_ev) begin
                match_flag_r <= 1'b1;
            end else if (wr_csr && !WDATA_IN[`CMIT_CSR_FLAG]) begin
                // flag clears only by writing zero
                match_flag_r <= 1'b0;
            end
            // a new constant applies at the next tick compare
            if (wr_const) begin
                compare_constant_r <= WDATA_IN[15:0];
            end
            // counter: software write first, then match, then tick
            // a load while running restarts the interval from that value
            if (wr_cnt) begin
                interval_counter_r <= WDATA_IN[15:0];
            end else if (match_ev) begin
                interval_counter_r <= 16'h0000;
            end else if (tick) begin
                // increment on tick; holds when stopped
                interval_counter_r <= interval_counter_r + 16'h0001;
            end
        end
    end

    // watchdog count and overflow pin
    // the count free-runs while enabled; the pin pulses for one cycle
    always @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            // stopped and cleared
            watchdog_count_r <= `CMIT_RST_WDCNT;
            wd_en_r <= 1'b0;
            OVF_OUT <= 1'b0;
        end else begin
            if (wr_wdctl) begin
                wd_en_r <= WDATA_IN[`CMIT_WD_EN];
            end
            // registered so the pin comes straight from a flop
            OVF_OUT <= wd_ovf_ev;
            // overflow or interrupt zeroes count
            // zeroing beats a software load in the same cycle
            if (wd_ovf_ev || irq_nxt) begin
                watchdog_count_r <= 8'h00;
            end else if (wr_wdcnt) begin
                watchdog_count_r <= WDATA_IN[7:0];
            end else if (wd_en_r) begin
                watchdog_count_r <= watchdog_count_r + 8'h01;
            end
        end
    end

    // sticky status, enables and interrupt outputs
    // both outputs follow next-state values, so they match the registers
    always @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            irq_stat_r <= 2'h0;
            irq_en_r <= 2'h0;
            IRQ_OUT <= 1'b0;
            MATCH_IRQ_OUT <= 1'b0;
        end else begin
            // event set beats write-one clear
            irq_stat_r <= stat_nxt;
            // enables reload only on their own write
            if (wr_ien) begin
                irq_en_r <= WDATA_IN[1:0];
            end
            // combined level from next status and next enable
            IRQ_OUT <= irq_nxt;
            MATCH_IRQ_OUT <= (match_flag_r || match_ev) && (wr_csr ? WDATA_IN[`CMIT_CSR_IE] : match_ie_r)
                && !(wr_csr && !WDATA_IN[`CMIT_CSR_FLAG] && !match_ev);
        end
    end

    // read data, one cycle after the strobe, zero otherwise
    // a read has no side effect; status clears only through its clear register
    always @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            RDATA_OUT <= 32'h00000000;
        end else if (RD_IN) begin
            case (ADDR_IN)
                `CMIT_OFF_START: RDATA_OUT <= {31'h00000000, count_start_bit_r};
                `CMIT_OFF_CSR: RDATA_OUT <= {24'h000000, csr_val};
                // counter read is the live value, not a snapshot
                `CMIT_OFF_CNT: RDATA_OUT <= {16'h0000, interval_counter_r};
                `CMIT_OFF_CONST: RDATA_OUT <= {16'h0000, compare_constant_r};
                `CMIT_OFF_WDCNT: RDATA_OUT <= {24'h000000, watchdog_count_r};
                `CMIT_OFF_IRQ_STAT: RDATA_OUT <= {30'h00000000, irq_stat_r};
                `CMIT_OFF_IRQ_EN: RDATA_OUT <= {30'h00000000, irq_en_r};
                `CMIT_OFF_WDCTL: RDATA_OUT <= {31'h00000000, wd_en_r};
                // unmapped and write-only read zero
                default: RDATA_OUT <= 32'h00000000;
            endcase
        end else begin
            // bus idle: zero, so the data stand only in the answer cycle
            RDATA_OUT <= 32'h00000000;
        end
    end
endmodule // cmit_timer
`default_nettype wire

// >>> verification/cmit_timer_chk.sv
// assertion checker for the interval timer ports
`timescale 1ns/1ns
`default_nettype none
`include "cmit_regs.vh"
module cmit_timer_chk (
    // clock and reset
    input wire logic CLK_IN,
    input wire logic RSTN_IN,
    // register port
    input wire logic [7:0] ADDR_IN,
    input wire logic [31:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    input wire logic [31:0] RDATA_OUT,
    // pins
    input wire logic OVF_OUT,
    input wire logic MATCH_IRQ_OUT,
    input wire logic IRQ_OUT
);
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RSTN_IN);
    // read data only stands after a strobe
    rd_idle_zero_a: assert property (!$past(RD_IN) |-> RDATA_OUT == 32'h0)
        else $error("read data not zero");
    rd_csr_bits_a: assert property (RD_IN && ADDR_IN == `CMIT_OFF_CSR |=> RDATA_OUT[31:8] == 0 && RDATA_OUT[5:2] == 0)
        else $error("csr unused bits set");
    rd_cnt_width_a: assert property (RD_IN && ADDR_IN == `CMIT_OFF_CNT |=> RDATA_OUT[31:16] == 16'h0)
        else $error("counter too wide");
    rd_wd_width_a: assert property (RD_IN && ADDR_IN == `CMIT_OFF_WDCNT |=> RDATA_OUT[31:8] == 24'h0)
        else $error("watchdog count too wide");
    rd_clr_zero_a: assert property (RD_IN && ADDR_IN == `CMIT_OFF_IRQ_CLR |=> RDATA_OUT == 32'h0)
        else $error("clear register readable");
    rd_hole_zero_a: assert property (RD_IN && ADDR_IN == 8'h24 |=> RDATA_OUT == 32'h0)
        else $error("unmapped read not zero");
    // a cleared enable drops the requests at once
    match_mask_a: assert property (WR_IN && ADDR_IN == `CMIT_OFF_CSR && !WDATA_IN[6] |=> !MATCH_IRQ_OUT)
        else $error("match request while masked");
    irq_mask_a: assert property (WR_IN && ADDR_IN == `CMIT_OFF_IRQ_EN && WDATA_IN[1:0] == 2'h0 |=> !IRQ_OUT)
        else $error("interrupt while masked");
    // overflow is a single pulse, count restarts from zero
    ovf_pulse_a: assert property (OVF_OUT |=> !OVF_OUT)
        else $error("overflow longer than one cycle");
    cover property (RD_IN && ADDR_IN == `CMIT_OFF_CNT);
    cover property ($rose(MATCH_IRQ_OUT));
    cover property ($rose(IRQ_OUT));
    cover property (OVF_OUT);
endmodule // cmit_timer_chk
bind cmit_timer cmit_timer_chk u_chk (.CLK_IN(CLK_IN), .RSTN_IN(RSTN_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN),
    .WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT), .OVF_OUT(OVF_OUT), .MATCH_IRQ_OUT(MATCH_IRQ_OUT),
    .IRQ_OUT(IRQ_OUT));
`default_nettype wire

// >>> verification/testbench.sv
// self-checking bench for the interval timer
`timescale 1ns/1ns
`default_nettype none
`include "cmit_regs.vh"
module testbench;
    // bench inputs and watched outputs
    logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic ovf, mirq, irq;
    int err_count = 0, checks = 0, n;
    cmit_timer DUT (.CLK_IN(clk), .RSTN_IN(rstn), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd),
        .RDATA_OUT(rdata), .OVF_OUT(ovf), .MATCH_IRQ_OUT(mirq), .IRQ_OUT(irq));
    // 4 ns clock
    initial begin
        forever #2 clk = ~clk;
    end
    // compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one-cycle write; returns after the taking edge has landed
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    // read strobe, data judged in the following cycle only
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask
    // bounded wait for a flag, one cycle per step
    task automatic wait_hi(ref logic sig);
        n = 0;
        while (sig !== 1'b1 && n < 400) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask
    task automatic t_reset_vals;
        rd_chk(`CMIT_OFF_CSR, 32'h0);
        rd_chk(`CMIT_OFF_CNT, 32'h0);
        rd_chk(`CMIT_OFF_CONST, 32'h0000FFFF);
        rd_chk(8'h24, 32'h0);
    endtask
    // constant 2 at clock over four: three ticks plus start latency, 13 cycles
    task automatic t_match;
        wr_reg(`CMIT_OFF_CONST, 32'h2);
        wr_reg(`CMIT_OFF_CSR, 32'h41);
        rd_chk(`CMIT_OFF_CNT, 32'h0);
        wr_reg(`CMIT_OFF_START, 32'h1);
        wait_hi(mirq);
        chk(n, 13);
        // stop before the next tick, so the cleared count must hold
        wr_reg(`CMIT_OFF_START, 32'h0);
        repeat (20) @(posedge clk);
        rd_chk(`CMIT_OFF_CNT, 32'h0);
        rd_chk(`CMIT_OFF_CSR, 32'hC1);
        rd_chk(`CMIT_OFF_IRQ_STAT, 32'h1);
        // select 00 at clock over eight, constant 0: one tick plus latency, 9 cycles
        wr_reg(`CMIT_OFF_CSR, 32'h40);
        wr_reg(`CMIT_OFF_CONST, 32'h0);
        wr_reg(`CMIT_OFF_START, 32'h1);
        wait_hi(mirq);
        chk(n, 9);
        wr_reg(`CMIT_OFF_START, 32'h0);
    endtask
    // masking and clearing of the match request, enabling and clearing of the combined one
    task automatic t_irq;
        chk(irq, 1'b0);
        wr_reg(`CMIT_OFF_IRQ_EN, 32'h1);
        chk(irq, 1'b1);
        wr_reg(`CMIT_OFF_CSR, 32'h81);
        chk(mirq, 1'b0);
        wr_reg(`CMIT_OFF_CSR, 32'hC1);
        chk(mirq, 1'b1);
        wr_reg(`CMIT_OFF_CSR, 32'h41);
        chk(mirq, 1'b0);
        rd_chk(`CMIT_OFF_CSR, 32'h41);
        wr_reg(`CMIT_OFF_IRQ_CLR, 32'h1);
        chk(irq, 1'b0);
    endtask
    // overflow pulse, then a pending interrupt pins the count at zero
    task automatic t_watchdog;
        wr_reg(`CMIT_OFF_WDCTL, 32'h1);
        wr_reg(`CMIT_OFF_WDCNT, 32'hFD);
        wait_hi(ovf);
        chk(ovf, 1'b1);
        rd_chk(`CMIT_OFF_IRQ_STAT, 32'h2);
        wr_reg(`CMIT_OFF_IRQ_EN, 32'h2);
        chk(irq, 1'b1);
        rd_chk(`CMIT_OFF_WDCNT, 32'h0);
        wr_reg(`CMIT_OFF_IRQ_EN, 32'h0);
        chk(irq, 1'b0);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // main sequence after 16 cycles of reset
    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        t_reset_vals();
        t_match();
        t_irq();
        t_watchdog();
        tally_and_finish();
    end
    // hang guard, far beyond the roughly 120 cycles needed
    initial begin
        #20000;
        err_count++;
        tally_and_finish();
    end
endmodule // testbench
`default_nettype wire
